// file: logic/epv_core.v
// Behaviour
// RL1: nmi always enabled, priority -2, top
// RL2: hard fault fixed priority -1
// RL3: hard fault on handling error or escalation
// RL4: memory fault on violation or execute-never fetch
// RL5: bus fault on bus error report
// RL6: bus fault precise sync, imprecise async
// RL7: usage fault on four instruction errors
// RL8: unaligned and divide usage faults when enabled
// RL9: supervisor call exception on instruction
// RL10: system tick on timer zero or software
// RL11: irq vectors from 0x40, 4-byte steps
// RL12: interrupt lines 0 to 49, own vectors
// RL13: software sets bit 0 of handlers
// RL14: vector base zero at reset, relocatable
// RL15: lower value wins, configurable 0 to 15
// RL16: configurable priorities reset to 0
// RL17: ties go to lowest exception number
// RL18: preempt only on strictly higher priority
// RL19: asynchronous entry may be delayed
// RL20: configurable exceptions can be disabled
// RL21: current exception number reported
// RL22: inactive, pending, active, active and pending
// RL23: winner re-evaluated every cycle
`timescale 1ns/100ps
`include "epv_map.vh"
module epv_core #(
  parameter IRQ_NUM = 50
) (
  input  wire                sys_clk_in,
  input  wire                rst_in,
  // apb slave
  input  wire                psel_in,
  input  wire                penable_in,
  input  wire                pwrite_in,
  input  wire [2:0]          pprot_in,
  input  wire [11:0]         paddr_in,
  input  wire [31:0]         pwdata_in,
  output reg  [31:0]         prdata_out,
  output reg                 pready_out,
  output reg                 pslverr_out,
  // exception sources
  input  wire                nmi_in,
  input  wire                exc_proc_err_in,
  input  wire                mpu_en_in,
  input  wire                mpu_violation_in,
  input  wire                execute_never_fetch_in,
  input  wire                bus_err_in,
  input  wire                bus_precise_in,
  input  wire                undef_instr_in,
  input  wire                illegal_unalign_in,
  input  wire                invalid_state_in,
  input  wire                exc_return_err_in,
  input  wire                unalign_access_in,
  input  wire                div_zero_in,
  input  wire                supervisor_call_in,
  input  wire                tick_zero_in,
  input  wire [IRQ_NUM-1:0]  irq_in,
  // core handshake
  input  wire                take_in,
  input  wire                return_in,
  output reg                 exc_req_out,
  output reg  [6:0]          exc_num_out,
  output reg  [31:0]         vec_addr_out,
  output reg                 exc_async_out,
  output reg  [6:0]          interrupt_program_status_out
);
  localparam NEXC = 16 + IRQ_NUM;   // exception numbers 0..NEXC-1
  // 0 is thread mode, 1 is reset;
  // reserved numbers never win

  // ---------------------------------------------------------------
  // software state
  // ---------------------------------------------------------------
  // changed by privileged writes only,
  // so user code cannot mask a fault
  reg  [1:0]   ctrl;           // usage fault report enables
  reg  [31:0]  vector_table_offset;
  reg  [5:0]   sys_en;         // mem, bus, usage, svc, pended_service_request, tick
  reg  [23:0]  sys_prio;       // six 4-bit priorities
  reg  [63:0]  irq_en;         // per-line enables
  reg  [255:0] irq_prio;       // 4 bits per line
  reg  [NEXC-1:0] pend;        // pending bit per exception
  reg  [NEXC-1:0] act;         // active bit per exception
  reg          bf_imprecise;   // last bus fault was imprecise

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // no wait states: ready is one
  // register behind setup
  wire setup   = psel_in & ~penable_in;
  wire priv    = pprot_in[0];
  // writes land only at the completing edge and only when privileged
  wire wr_en   = psel_in & penable_in & pready_out & pwrite_in & priv;
  wire addr_ok = (paddr_in <= `EPV_SYSPND_OFS) & (paddr_in[1:0] == 2'b00) &
                 ~((paddr_in > `EPV_IRQEN1_OFS) & (paddr_in < `EPV_IRQPRIO_OFS));
  wire [2:0] prio_word = paddr_in[4:2];

  // software one-shot requests from the control word
  wire wr_ctrl    = wr_en & (paddr_in == `EPV_CTRL_OFS);
  wire sw_pended_service_request  = wr_ctrl & pwdata_in[`EPV_CTRL_PENDED_SERVICE_REQUEST];
  wire sw_system_tick_exception = wr_ctrl & pwdata_in[`EPV_CTRL_SYSTEM_TICK_EXCEPTION];
  wire sw_nmi     = wr_ctrl & pwdata_in[`EPV_CTRL_NMI];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // reset: all disabled, priority 0,
  // table at address zero
  // read-only and reserved words
  // fall through untouched
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl                <= 2'h0;
      vector_table_offset <= `EPV_VTOR_RST;           // RL14
      sys_en              <= 6'h00;
      sys_prio            <= 24'h000000;              // RL16
      irq_en              <= 64'h0000000000000000;
      irq_prio            <= 256'h0;                  // RL16
    end else if (wr_en) begin
      case (paddr_in)
        `EPV_CTRL_OFS:    ctrl <= pwdata_in[1:0];
        // base kept inside the relocatable window, low bits forced clear
        `EPV_VTOR_OFS:    vector_table_offset <= pwdata_in & `EPV_VTOR_MASK; // RL14
        `EPV_SYSEN_OFS:   sys_en <= pwdata_in[5:0];   // RL20
        `EPV_SYSPRIO_OFS: sys_prio <= pwdata_in[23:0];
        `EPV_IRQEN0_OFS:  irq_en[31:0] <= pwdata_in;  // RL20
        `EPV_IRQEN1_OFS:  irq_en[63:32] <= pwdata_in;
        default: begin
          // one word per eight lines of priority
          if ((paddr_in >= `EPV_IRQPRIO_OFS) && (paddr_in < `EPV_STATUS_OFS)) begin
            irq_prio[prio_word*32 +: 32] <= pwdata_in;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // enable and effective priority per exception
  // ---------------------------------------------------------------
  // effective priority: nmi 1, hard 2, configurable 16+p; smaller wins
  // two extra top bits rank fixed
  // priorities above any field value,
  // so one unsigned compare serves all
  reg  [NEXC-1:0]   en;
  reg  [NEXC*6-1:0] eff;
  integer           k;
  always @* begin
    en  = {NEXC{1'b0}};
    eff = {NEXC{`EPV_PRIO_IDLE}};
    en[2]  = 1'b1;                                    // RL1
    eff[2*6 +: 6] = `EPV_PRIO_NMI;                    // RL1
    en[3]  = 1'b1;                                    // RL2
    eff[3*6 +: 6] = `EPV_PRIO_HARD;                   // RL2
    en[4]  = sys_en[0];
    en[5]  = sys_en[1];
    en[6]  = sys_en[2];
    en[11] = sys_en[3];
    en[14] = sys_en[4];
    en[15] = sys_en[5];
    eff[4*6 +: 6]  = {2'b01, sys_prio[3:0]};          // RL15
    eff[5*6 +: 6]  = {2'b01, sys_prio[7:4]};
    eff[6*6 +: 6]  = {2'b01, sys_prio[11:8]};
    eff[11*6 +: 6] = {2'b01, sys_prio[15:12]};
    eff[14*6 +: 6] = {2'b01, sys_prio[19:16]};
    eff[15*6 +: 6] = {2'b01, sys_prio[23:20]};
    for (k = 0; k < IRQ_NUM; k = k + 1) begin
      en[16+k] = irq_en[k];                           // RL12
      eff[(16+k)*6 +: 6] = {2'b01, irq_prio[k*4 +: 4]}; // RL15
    end
  end

  // ---------------------------------------------------------------
  // priority search
  // ---------------------------------------------------------------
  // one pass finds the pending winner, the current priority and the
  // active exception that resumes after a return
  // reset is the reset pin itself,
  // so the search starts at 2
  // trade-off: a long linear chain
  // instead of a tree keeps the
  // winner in the same cycle as pending
  reg  [6:0] win_num;
  reg  [5:0] win_prio;
  reg  [6:0] nxt_num;
  reg  [5:0] nxt_prio;
  reg  [5:0] cur_prio;
  reg  [5:0] p;
  integer    i;
  always @* begin
    win_num  = 7'h00;
    win_prio = `EPV_PRIO_IDLE;
    nxt_num  = 7'h00;
    nxt_prio = `EPV_PRIO_IDLE;
    cur_prio = `EPV_PRIO_IDLE;
    p        = `EPV_PRIO_IDLE;
    for (i = 2; i < NEXC; i = i + 1) begin
      p = eff[i*6 +: 6];
      // strict compare keeps the lowest number on a tie
      if (pend[i] && en[i] && (p < win_prio)) begin     // RL17 RL23
        win_num  = i[6:0];
        win_prio = p;
      end
      // most urgent other active one
      if (act[i] && (i[6:0] != interrupt_program_status_out) &&
          (p < nxt_prio)) begin
        nxt_num  = i[6:0];
        nxt_prio = p;
      end
      // running handler's priority
      if (i[6:0] == interrupt_program_status_out) begin
        cur_prio = p;
      end
    end
  end

  // ---------------------------------------------------------------
  // event classification and escalation
  // ---------------------------------------------------------------
  // every high cycle of a source is
  // a fresh request
  // execute-never fetches fault even
  // with the protection unit off
  wire mm_evt = (mpu_en_in & mpu_violation_in) | execute_never_fetch_in; // RL4
  wire uf_evt = undef_instr_in | illegal_unalign_in | invalid_state_in |
                exc_return_err_in;                                       // RL7
  wire uf_opt = (unalign_access_in & ctrl[`EPV_CTRL_UNALIGN]) |
                (div_zero_in & ctrl[`EPV_CTRL_DIVZERO]);                 // RL8
  wire bf_sync  = bus_err_in & bus_precise_in;                           // RL5 RL6
  wire bf_async = bus_err_in & ~bus_precise_in;                          // RL6
  // a synchronous fault that is disabled or cannot preempt now has no
  // handler able to run, so it escalates instead of pending
  wire esc_mm  = ~sys_en[0] | ({2'b01, sys_prio[3:0]} >= cur_prio);
  wire esc_bf  = ~sys_en[1] | ({2'b01, sys_prio[7:4]} >= cur_prio);
  wire esc_uf  = ~sys_en[2] | ({2'b01, sys_prio[11:8]} >= cur_prio);
  wire esc_svc = ~sys_en[3] | ({2'b01, sys_prio[15:12]} >= cur_prio);
  wire hf_evt  = exc_proc_err_in | (mm_evt & esc_mm) | (bf_sync & esc_bf) |
                 ((uf_evt | uf_opt) & esc_uf) |
                 (supervisor_call_in & esc_svc);                         // RL3

  // imprecise bus errors never
  // escalate: the access has retired
  reg [NEXC-1:0] evt;   // set requests this cycle
  always @* begin
    evt     = {NEXC{1'b0}};
    evt[2]  = nmi_in | sw_nmi;                                           // RL1
    evt[3]  = hf_evt;                                                    // RL3
    evt[4]  = mm_evt & ~esc_mm;                                          // RL4
    evt[5]  = (bf_sync & ~esc_bf) | bf_async;                            // RL5
    evt[6]  = (uf_evt | uf_opt) & ~esc_uf;                               // RL7 RL8
    evt[11] = supervisor_call_in & ~esc_svc;                             // RL9
    evt[14] = sw_pended_service_request;
    evt[15] = tick_zero_in | sw_system_tick_exception;                                 // RL10
    evt[NEXC-1:16] = irq_in;                                             // RL12
  end

  // ---------------------------------------------------------------
  // per-exception pending and active state
  // ---------------------------------------------------------------
  // a new request in the cycle of entry keeps pending set, giving
  // active and pending for a source already in service
  // reserved numbers never pend:
  // no event or take reaches them
  genvar g;
  generate
    for (g = 0; g < NEXC; g = g + 1) begin : g_state
      wire taken = take_in & (exc_num_out == g);
      wire done  = return_in & (interrupt_program_status_out == g);
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pend[g] <= 1'b0;
          act[g]  <= 1'b0;
        end else begin
          pend[g] <= evt[g] | (pend[g] & ~taken);     // RL22
          act[g]  <= taken | (act[g] & ~done);        // RL22
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // current exception and request outputs
  // ---------------------------------------------------------------
  wire preempt = (win_num != 7'h00) & (win_prio < cur_prio);           // RL18
  // limitation: a take must come
  // while exc_req_out is high
  // asynchronous winners may be entered after further instructions
  wire win_sync = (win_num == `EPV_NUM_HARD) | (win_num == `EPV_NUM_MEM) |
                  (win_num == `EPV_NUM_USAGE) | (win_num == `EPV_NUM_SVC) |
                  ((win_num == `EPV_NUM_BUS) & ~bf_imprecise);

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_program_status_out <= 7'h00;
      exc_req_out   <= 1'b0;
      exc_num_out   <= 7'h00;
      vec_addr_out  <= `EPV_VTOR_RST;
      exc_async_out <= 1'b0;
      bf_imprecise  <= 1'b0;
    end else begin
      // entry makes the taken exception current; return resumes the
      // most urgent still-active one, or thread mode
      if (take_in) begin
        interrupt_program_status_out <= exc_num_out;            // RL21
      end else if (return_in) begin
        interrupt_program_status_out <= nxt_num;                // RL21
      end
      // kind of last bus error picks
      // sync or async bus fault entry
      if (bus_err_in) begin
        bf_imprecise <= ~bus_precise_in;                        // RL6
      end
      exc_req_out   <= preempt & ~take_in;                      // RL18 RL23
      exc_num_out   <= win_num;
      // vector = base + 4 * exception number, irq n at 0x40 + 4n
      vec_addr_out  <= vector_table_offset + {23'h000000, win_num, 2'b00}; // RL11
      exc_async_out <= ~win_sync;                               // RL19
    end
  end

  // ---------------------------------------------------------------
  // apb answer: data and error captured in setup, ready in access
  // ---------------------------------------------------------------
  // data chosen at setup and held,
  // so access shows settled data
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr_in)
      `EPV_CTRL_OFS:    rd_mux = {30'h00000000, ctrl};
      `EPV_VTOR_OFS:    rd_mux = vector_table_offset;
      `EPV_SYSEN_OFS:   rd_mux = {26'h0000000, sys_en};
      `EPV_SYSPRIO_OFS: rd_mux = {8'h00, sys_prio};
      `EPV_IRQEN0_OFS:  rd_mux = irq_en[31:0];
      `EPV_IRQEN1_OFS:  rd_mux = irq_en[63:32];
      // current, winner, request flag
      `EPV_STATUS_OFS:  rd_mux = {15'h0000, exc_req_out, 1'b0, exc_num_out,
                                  1'b0, interrupt_program_status_out};
      `EPV_IRQPND0_OFS: rd_mux = pend[47:16];
      // only lines 32 to 49 exist here
      `EPV_IRQPND1_OFS: rd_mux = {{(80-NEXC){1'b0}}, pend[NEXC-1:48]};
      // pending low half, active high
      `EPV_SYSPND_OFS:  rd_mux = {act[15:0], pend[15:0]};
      default: begin
        if ((paddr_in >= `EPV_IRQPRIO_OFS) && (paddr_in < `EPV_STATUS_OFS)) begin
          rd_mux = irq_prio[prio_word*32 +: 32];
        end
      end
    endcase
  end

  // ready lasts one cycle; the error
  // flag is shown only alongside it
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      if (setup) begin
        // unmapped or unprivileged write answers with an error
        pslverr_out <= ~addr_ok | (pwrite_in & ~priv);          // RL14 RL20
        prdata_out  <= (addr_ok & ~pwrite_in) ? rd_mux : 32'h00000000;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end
endmodule

// file: logic/epv_map.vh
`ifndef EPV_MAP_VH
`define EPV_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EPV_CTRL_OFS     12'h000
`define EPV_VTOR_OFS     12'h004
`define EPV_SYSEN_OFS    12'h008
`define EPV_SYSPRIO_OFS  12'h00C
`define EPV_IRQEN0_OFS   12'h010
`define EPV_IRQEN1_OFS   12'h014
`define EPV_IRQPRIO_OFS  12'h020
`define EPV_STATUS_OFS   12'h040
`define EPV_IRQPND0_OFS  12'h044
`define EPV_IRQPND1_OFS  12'h048
`define EPV_SYSPND_OFS   12'h04C
// ---------------------------------------------------------------
// fields and values
// ---------------------------------------------------------------
`define EPV_CTRL_UNALIGN 0
`define EPV_CTRL_DIVZERO 1
`define EPV_CTRL_PENDED_SERVICE_REQUEST  8
`define EPV_CTRL_SYSTEM_TICK_EXCEPTION 9
`define EPV_CTRL_NMI     10
`define EPV_VTOR_RST     32'h00000000
`define EPV_VTOR_MASK    32'h03FFFF80
`define EPV_PRIO_NMI     6'h01
`define EPV_PRIO_HARD    6'h02
`define EPV_PRIO_IDLE    6'h3F
`define EPV_PRIO_RST     4'h0
`define EPV_IRQ_BASE     7'h10
`define EPV_NUM_NMI      7'h02
`define EPV_NUM_HARD     7'h03
`define EPV_NUM_MEM      7'h04
`define EPV_NUM_BUS      7'h05
`define EPV_NUM_USAGE    7'h06
`define EPV_NUM_SVC      7'h0B
`define EPV_NUM_PENDED_SERVICE_REQUEST   7'h0E
`define EPV_NUM_TICK     7'h0F
`endif

// file: tb/epv_core_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// port checks of the exception unit
// ----------------------------------------------------------
module epv_core_assertions (
  input logic        sys_clk_in,
  input logic        rst_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [2:0]  pprot_in,
  input logic        pready_out,
  input logic        pslverr_out,
  input logic        nmi_in,
  input logic        exc_proc_err_in,
  input logic        take_in,
  input logic        exc_req_out,
  input logic [6:0]  exc_num_out,
  input logic [31:0] vec_addr_out,
  input logic        exc_async_out,
  input logic [6:0]  interrupt_program_status_out
);
  // one clock domain, reset drops every check
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  nmi_top_a: assert property
    ((nmi_in && interrupt_program_status_out != 7'h02 && !take_in && !exc_req_out)
     ##1 !take_in |=> exc_req_out && exc_num_out == 7'h02) else $error("nmi not requested");
  nmi_kept_a: assert property
    (interrupt_program_status_out == 7'h02 |-> !exc_req_out) else $error("nmi preempted");
  hard_rank_a: assert property
    (interrupt_program_status_out == 7'h03 |-> !exc_req_out || exc_num_out == 7'h02)
    else $error("hard fault preempted");
  hard_raise_a: assert property
    ((exc_proc_err_in && !nmi_in && !take_in && !exc_req_out
      && interrupt_program_status_out == 7'h00) ##1 (!take_in && !nmi_in)
     |=> exc_req_out && exc_num_out == 7'h03) else $error("hard fault missing");
  vec_step_a: assert property
    (vec_addr_out[6:0] == {exc_num_out[4:0], 2'b00}) else $error("vector offset wrong");
  sync_kind_a: assert property
    (exc_req_out && (exc_num_out == 7'h04 || exc_num_out == 7'h06 || exc_num_out == 7'h0B)
     |-> !exc_async_out) else $error("sync fault flagged async");
  irq_async_a: assert property
    (exc_req_out && exc_num_out >= 7'h10 |-> exc_async_out) else $error("irq not async");
  take_status_a: assert property
    (take_in && exc_req_out |=> !exc_req_out
     && interrupt_program_status_out == $past(exc_num_out)) else $error("status not updated");
  apb_ready_a: assert property
    (psel_in && !penable_in |=> pready_out ##1 !pready_out) else $error("ready timing");
  apb_refuse_a: assert property
    (psel_in && !penable_in && pwrite_in && !pprot_in[0] |=> pslverr_out)
    else $error("user write accepted");
endmodule

bind epv_core epv_core_assertions u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pprot_in(pprot_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .nmi_in(nmi_in),
  .exc_proc_err_in(exc_proc_err_in), .take_in(take_in), .exc_req_out(exc_req_out),
  .exc_num_out(exc_num_out), .vec_addr_out(vec_addr_out), .exc_async_out(exc_async_out),
  .interrupt_program_status_out(interrupt_program_status_out));

// file: tb/epv_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// core model: enters and leaves handlers
// ----------------------------------------------------------
module epv_core_model (
  input  logic       sys_clk_in,
  input  logic       rst_in,
  input  logic       exc_req_in,  // entry request from the unit
  input  logic [6:0] status_in,   // handler now running
  input  logic       slow_in,     // hold entry off a few cycles
  output logic       take_out,    // handler entry pulse
  output logic       return_out   // handler exit pulse
);
  logic [2:0] wait_cnt;           // cycles the request has stood
  logic [3:0] run_cnt;            // handler time left
  // never take and return together: the unit would see both on one edge
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      take_out   <= 1'b0;
      return_out <= 1'b0;
      wait_cnt   <= 3'h0;
      run_cnt    <= 4'h0;
    end else begin
      take_out   <= 1'b0;
      return_out <= 1'b0;
      if (run_cnt != 4'h0)
        run_cnt <= run_cnt - 4'h1;
      if (exc_req_in && !take_out) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (!slow_in || wait_cnt == 3'h4) begin
          take_out <= 1'b1;
          wait_cnt <= 3'h0;
          run_cnt  <= 4'hC;
        end
      end else if (status_in != 7'h00 && run_cnt == 4'h0 && !return_out) begin
        // only a running handler returns; gap lets status settle
        return_out <= 1'b1;
        run_cnt    <= 4'h3;
      end
    end
  end
endmodule

// file: tb/exception_priority_vectoring_bench.sv
`timescale 1ns/100ps
`include "epv_map.vh"
// ----------------------------------------------------------
// self-checking bench of the exception unit
// ----------------------------------------------------------
module exception_priority_vectoring_bench;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mpu_en = 1'b1, precise = 1'b1;
  logic [2:0]  pprot = 3'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, vec, d, vt = 32'h0;
  logic [62:0] src = 63'h0;       // irq lines, then nmi and fault sources
  logic        pready, pslverr, take, ret, req, asy, slow = 1'b0;
  logic [6:0]  num, stat;
  logic [33:0] r;
  logic [33:0] rq[$];             // expected bus answers: read, error, data
  logic [39:0] eq[$];             // expected entries: async kind, vector, number
  logic [6:0]  fx[13] = '{7'h02, 7'h03, 7'h04, 7'h04, 7'h05, 7'h06, 7'h06,
                          7'h06, 7'h06, 7'h06, 7'h06, 7'h0B, 7'h0F};
  logic [6:0]  sw[3] = '{7'h0E, 7'h0F, 7'h02};
  integer      seed = 32'h6a878970;
  int          fails = 0, n_tests = 0, cyc = 0, n;

  always #5 sys_clk_in = ~sys_clk_in;

  epv_core dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pprot_in(pprot), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .nmi_in(src[50]), .exc_proc_err_in(src[51]), .mpu_en_in(mpu_en),
    .mpu_violation_in(src[52]), .execute_never_fetch_in(src[53]), .bus_err_in(src[54]),
    .bus_precise_in(precise), .undef_instr_in(src[55]), .illegal_unalign_in(src[56]),
    .invalid_state_in(src[57]), .exc_return_err_in(src[58]), .unalign_access_in(src[59]),
    .div_zero_in(src[60]), .supervisor_call_in(src[61]), .tick_zero_in(src[62]),
    .irq_in(src[49:0]), .take_in(take), .return_in(ret), .exc_req_out(req),
    .exc_num_out(num), .vec_addr_out(vec), .exc_async_out(asy),
    .interrupt_program_status_out(stat));

  epv_core_model u_core (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .exc_req_in(req),
    .status_in(stat), .slow_in(slow), .take_out(take), .return_out(ret));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one bus transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                     input logic p, input logic e);
    rq.push_back({~w, e, w ? 32'h0 : dd});
    @(posedge sys_clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dd;
    pprot   <= {2'b00, p};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1) @(posedge sys_clk_in);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ex(input logic [6:0] x);
    // nmi, pended service, tick and lines are async; bus fault only when imprecise
    eq.push_back({(x == 7'h02) | (x >= 7'h0E) | ((x == 7'h05) & ~d[0]),
                  vt + {23'h0, x, 2'b00}, x});
  endtask

  task automatic pulse(input logic [62:0] m);
    @(posedge sys_clk_in);
    src <= m;
    @(posedge sys_clk_in);
    src <= 63'h0;
  endtask

  // wait until every expected entry was taken and the core is back in thread
  task automatic settle();
    repeat (4) @(posedge sys_clk_in);
    while (eq.size() != 0 || stat !== 7'h00 || req !== 1'b0) @(posedge sys_clk_in);
  endtask

  // monitor: oldest note against each answer or entry
  always @(posedge sys_clk_in) begin
    cyc++;
    if (pready && psel && penable) begin
      r = rq.pop_front();
      chk({pslverr, r[33] ? prdata : 32'h0}, r[32:0]);
    end
    if (take) begin
      chk({asy, vec, num}, eq.size() != 0 ? eq.pop_front() : {40{1'b1}});
      // handler words sit on word steps; bit 0 is software's marker
      chk(vec[1:0], 2'h0);
    end
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, `EPV_VTOR_OFS, 32'h0, 1'b1, 1'b0);
    apb(1'b0, `EPV_SYSPRIO_OFS, 32'h0, 1'b1, 1'b0);
    apb(1'b0, `EPV_IRQPRIO_OFS, 32'h0, 1'b1, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 1'b1, 1'b1);
    d = $random(seed);
    apb(1'b1, `EPV_VTOR_OFS, d, 1'b0, 1'b1);
    apb(1'b0, `EPV_VTOR_OFS, 32'h0, 1'b1, 1'b0);
    apb(1'b1, `EPV_VTOR_OFS, d, 1'b1, 1'b0);
    vt = d & `EPV_VTOR_MASK;
    apb(1'b0, `EPV_VTOR_OFS, vt, 1'b1, 1'b0);
    $display("test registers done");
    // faults escalate while their handlers are off
    ex(7'h03);
    pulse(63'h1 << 55);
    settle();
    apb(1'b1, `EPV_SYSEN_OFS, 32'h3F, 1'b1, 1'b0);
    pulse(63'h3 << 59);
    settle();
    apb(1'b1, `EPV_CTRL_OFS, 32'h3, 1'b1, 1'b0);
    for (int j = 1; j < 13; j++) begin
      mpu_en  <= (j != 3);
      d = $random(seed);
      precise <= d[0];
      ex(fx[j]);
      pulse(63'h1 << (50 + j));
      settle();
    end
    for (int k = 0; k < 3; k++) begin
      ex(sw[k]);
      apb(1'b1, `EPV_CTRL_OFS, 32'h3 | (32'h100 << k), 1'b1, 1'b0);
      settle();
    end
    $display("test faults done");
    apb(1'b1, `EPV_IRQEN0_OFS, 32'hFFFFFFF7, 1'b1, 1'b0);
    apb(1'b1, `EPV_IRQEN1_OFS, 32'h0003FFFF, 1'b1, 1'b0);
    ex(7'h12);
    ex(7'h15);
    pulse(63'h24);
    settle();
    for (int k = 0; k < 8; k++) begin
      n = {$random(seed)} % 50;
      if (n == 3)
        n = 49;
      slow <= $random(seed);
      ex(7'h10 + n[6:0]);
      pulse(63'h1 << n);
      settle();
    end
    slow <= 1'b0;
    ex(7'h10);
    ex(7'h02);
    pulse(63'h1);
    while (stat !== 7'h10) @(posedge sys_clk_in);
    pulse(63'h1 << 50);
    settle();
    apb(1'b1, `EPV_IRQPRIO_OFS, 32'h35, 1'b1, 1'b0);
    ex(7'h11);
    ex(7'h10);
    pulse(63'h3);
    settle();
    pulse(63'h8);
    settle();
    apb(1'b0, `EPV_IRQPND0_OFS, 32'h8, 1'b1, 1'b0);
    ex(7'h13);
    apb(1'b1, `EPV_IRQEN0_OFS, 32'hFFFFFFFF, 1'b1, 1'b0);
    settle();
    $display("test interrupts done");
    end_of_test();
  end
endmodule
